/* hrcsc_ctrl.sv */
// hub reset, clock, strap, thermal alert and chain test control
`timescale 1ns/1ps

// Operation
// - Asserting the reset input clears all internal state at once, without a clock edge.
// - While reset is asserted every pcie attach output is released to high impedance.
// - Concurrent select low means video or pcie alone, high means both share the port.
// - Lane reversal select low numbers the pcie lanes backwards, high numbers them normally.
// - Onset of the thermal alert starts the thermal management response.
// - All pcie clocks come from the 100 MHz differential serial reference input.
// - Host domain logic runs on the differential host clock, and memory clocks derive from it.
// - The tester drives the high-impedance test pin to start the chain, which then carries out the result.
module hrcsc_ctrl
  import hrcsc_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  input  wire logic                    async_reset_in_n,
  input  wire logic                    core_power_good,
  input  wire logic                    thermal_alert_in_n,
  input  wire logic                    concurrent_video_select,
  input  wire logic                    lane_reversal_select,
  input  wire logic                    host_clock_pos,
  input  wire logic                    host_clock_neg,
  input  wire logic                    serial_ref_clock_pos,
  input  wire logic                    serial_ref_clock_neg,
  input  wire logic                    chain_test_pin_in,
  output logic                         chain_test_pin_out,
  output logic                         chain_test_pin_oe_n,
  input  wire logic                    hiz_test_pin_in,
  output logic                         hiz_test_pin_out,
  output logic                         hiz_test_pin_oe_n,
  output logic                         host_domain_clk,
  output logic                         mem_domain_clk,
  output logic                         pcie_ref_clk,
  output logic                         pcie_out_oe_n,
  output logic                         core_ready,
  output hrcsc_strap_t                 strap,
  output logic [LANES-1:0][LANE_W-1:0] lane_map,
  output hrcsc_therm_t                 therm
);

  // ----------------------------------------------------------------
  // reset and clock receivers
  // ----------------------------------------------------------------
  logic any_rst;
  assign any_rst = srst | ~async_reset_in_n;

  // differential receivers: a pair reads high when pos is above neg
  assign host_domain_clk = host_clock_pos & ~host_clock_neg;
  assign mem_domain_clk  = host_clock_pos & ~host_clock_neg;
  assign pcie_ref_clk    = serial_ref_clock_pos & ~serial_ref_clock_neg;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hrcsc_state_t state_reg, state_next;
  logic [1:0]   pg_sync_reg, pg_sync_next;
  logic [1:0]   th_sync_reg, th_sync_next;
  logic         th_prev_reg, th_prev_next;
  logic         strap_open_reg, strap_open_next;
  hrcsc_strap_t strap_reg, strap_next;
  hrcsc_therm_t therm_reg, therm_next;
  logic         chain_reg, chain_next;
  logic         pcie_on_reg, pcie_on_next;

  // next-state logic for sequencing, straps, thermal alert and chain
  always_comb begin
    state_next      = state_reg;
    pg_sync_next    = {pg_sync_reg[0], core_power_good};
    th_sync_next    = {th_sync_reg[0], thermal_alert_in_n};
    th_prev_next    = th_sync_reg[1];
    strap_open_next = 1'b0;
    strap_next      = strap_reg;
    therm_next      = therm_reg;
    chain_next      = chain_reg;
    pcie_on_next    = pcie_on_reg;
    // straps follow the pins while srst holds and at the first edge after the reset input releases, then freeze
    if (srst || strap_open_reg) begin
      strap_next.concurrent    = (concurrent_video_select == CONC_BOTH);
      strap_next.lane_reversed = (lane_reversal_select == SLR_REVERSED);
    end
    // alert onset gives one pulse, the level stays while active
    therm_next.thermal_active = (th_sync_reg[1] == THERM_ACTIVE);
    therm_next.thermal_event  = (th_sync_reg[1] == THERM_ACTIVE) &&
                                (th_prev_reg != THERM_ACTIVE);
    // chain result is the parity of the strap, alert, power good and chain test pin inputs
    chain_next = ^{concurrent_video_select, lane_reversal_select, thermal_alert_in_n,
                   core_power_good, chain_test_pin_in};
    case (state_reg)
      HRCSC_RESET: begin
        pcie_on_next = 1'b0;
        state_next   = HRCSC_PWRWAIT;
      end
      HRCSC_PWRWAIT: begin
        // power good already implies the supply has settled
        if (pg_sync_reg[1]) begin
          state_next   = HRCSC_RUN;
          pcie_on_next = 1'b1;
        end
      end
      HRCSC_RUN: begin
        if (!pg_sync_reg[1]) begin
          state_next   = HRCSC_PWRWAIT;
          pcie_on_next = 1'b0;
        end else if (hiz_test_pin_in) begin
          // tester drives the pin to start the chain test
          state_next   = HRCSC_CHAIN;
          pcie_on_next = 1'b0;
        end
      end
      HRCSC_CHAIN: begin
        state_next   = HRCSC_CHAIN;  // left only by reset
        pcie_on_next = 1'b0;
      end
      default: begin
        state_next   = HRCSC_RESET;
        pcie_on_next = 1'b0;
      end
    endcase
  end

  // registers: async reset input clears to constants, srst likewise except the straps, which keep tracking the pins
  always_ff @(posedge ref_clk or negedge async_reset_in_n) begin
    if (!async_reset_in_n) begin
      state_reg      <= HRCSC_RESET;
      pg_sync_reg    <= SYNC_RST;
      th_sync_reg    <= THERM_SYNC_RST;
      th_prev_reg    <= 1'b1;
      strap_open_reg <= 1'b1;
      strap_reg      <= '0;
      therm_reg      <= '0;
      chain_reg      <= 1'b0;
      pcie_on_reg    <= 1'b0;
    end else if (srst) begin
      state_reg      <= HRCSC_RESET;
      pg_sync_reg    <= SYNC_RST;
      th_sync_reg    <= THERM_SYNC_RST;
      th_prev_reg    <= 1'b1;
      strap_open_reg <= 1'b0;        // straps already sampled here, frozen on release
      strap_reg      <= strap_next;  // straps track pins during reset
      therm_reg      <= '0;
      chain_reg      <= 1'b0;
      pcie_on_reg    <= 1'b0;
    end else begin
      state_reg      <= state_next;
      pg_sync_reg    <= pg_sync_next;
      th_sync_reg    <= th_sync_next;
      th_prev_reg    <= th_prev_next;
      strap_open_reg <= strap_open_next;
      strap_reg      <= strap_next;
      therm_reg      <= therm_next;
      chain_reg      <= chain_next;
      pcie_on_reg    <= pcie_on_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign core_ready          = pcie_on_reg;
  assign strap               = strap_reg;
  assign therm               = therm_reg;
  assign pcie_out_oe_n       = any_rst | ~pcie_on_reg;
  assign chain_test_pin_out  = 1'b0;
  assign chain_test_pin_oe_n = 1'b1;  // chain pin is only an input
  assign hiz_test_pin_out    = chain_reg;
  assign hiz_test_pin_oe_n   = any_rst | (state_reg != HRCSC_CHAIN);

  // lane numbering, one entry per physical lane
  genvar gi;
  generate
    for (gi = 0; gi < LANES; gi++) begin : g_lane
      assign lane_map[gi] = strap_reg.lane_reversed ?
                            LANE_W'(LANES - 1 - gi) : LANE_W'(gi);
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  tri_in_reset_a: assert property (@(posedge ref_clk) any_rst |-> pcie_out_oe_n)
    else $error("pcie outputs driven during reset");
  state_cleared_a: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(async_reset_in_n) |-> state_reg == HRCSC_RESET)
    else $error("state not cleared by reset input");
  ready_after_pg_a: assert property (@(posedge ref_clk) disable iff (any_rst)
      (state_reg == HRCSC_PWRWAIT && pg_sync_reg[1]) |=> core_ready)
    else $error("power good did not release the core");
  no_ready_wo_pg_a: assert property (@(posedge ref_clk) disable iff (any_rst)
      core_ready |-> $past(pg_sync_reg[1]))
    else $error("ready without power good");
  conc_decode_a: assert property (@(posedge ref_clk)
      srst |=> strap.concurrent == $past(concurrent_video_select))
    else $error("concurrent select decoded wrong");
  lane_decode_a: assert property (@(posedge ref_clk)
      srst |=> strap.lane_reversed == !$past(lane_reversal_select))
    else $error("lane reversal decoded wrong");
  lane_map_a: assert property (@(posedge ref_clk) disable iff (srst)
      lane_map[0] == (strap.lane_reversed ? 4'hf : 4'h0))
    else $error("lane zero mapped wrong");
  strap_hold_a: assert property (@(posedge ref_clk) disable iff (any_rst)
      !strap_open_reg |=> $stable(strap))
    else $error("strap changed outside reset");
  therm_pulse_a: assert property (@(posedge ref_clk) disable iff (any_rst)
      $fell(thermal_alert_in_n) ##0 th_prev_reg |-> ##3 therm.thermal_event)
    else $error("thermal alert onset missed");
  therm_once_a: assert property (@(posedge ref_clk) disable iff (any_rst)
      therm.thermal_event |=> !therm.thermal_event)
    else $error("thermal event longer than one cycle");
  chain_drive_a: assert property (@(posedge ref_clk) disable iff (any_rst)
      (state_reg == HRCSC_RUN && pg_sync_reg[1] && hiz_test_pin_in) |=> !hiz_test_pin_oe_n)
    else $error("chain result not driven");
  host_clk_a: assert property (@(posedge ref_clk)
      mem_domain_clk == host_domain_clk)
    else $error("memory clock not from host clock");

endmodule

/* hrcsc_pkg.sv */
// package of constants and types for the hub reset, clock and strap control block
package hrcsc_pkg;

  // ----------------------------------------------------------------
  // widths, strap encodings and alert polarity
  // ----------------------------------------------------------------
  localparam int unsigned  LANES          = 16;
  localparam int unsigned  LANE_W         = 4;
  localparam logic         CONC_ONE_ONLY  = 1'b0;  // one of video or pcie active
  localparam logic         CONC_BOTH      = 1'b1;  // both share the pcie port
  localparam logic         SLR_REVERSED   = 1'b0;  // lanes numbered backwards
  localparam logic         SLR_NORMAL     = 1'b1;  // lanes numbered forwards
  localparam logic         THERM_ACTIVE   = 1'b0;  // alert input is active low

  // ----------------------------------------------------------------
  // clock and power-up timing figures
  // ----------------------------------------------------------------
  localparam int unsigned  SERIAL_REF_MHZ = 100;
  localparam int unsigned  PWR_STABLE_US  = 10;    // platform hold before power good

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]   SYNC_RST       = 2'h0;
  localparam logic [1:0]   THERM_SYNC_RST = 2'h3;  // idle level of the alert

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    HRCSC_RESET   = 2'b00,
    HRCSC_PWRWAIT = 2'b01,
    HRCSC_RUN     = 2'b11,
    HRCSC_CHAIN   = 2'b10
  } hrcsc_state_t;

  typedef struct packed {
    logic concurrent;     // video and pcie run together
    logic lane_reversed;  // pcie lanes numbered backwards
  } hrcsc_strap_t;

  typedef struct packed {
    logic thermal_active; // alert level, synchronised
    logic thermal_event;  // one-cycle pulse on alert onset
  } hrcsc_therm_t;

endpackage

/* hrcsc_platform.sv */
// platform model: clock synthesizer pairs, hub reset and power good
`timescale 1ns/1ps
module hrcsc_platform
  import hrcsc_pkg::*;
#(
  parameter int HOST_HALF_NS = 6  // host clock rate is a free choice
)(
  input  wire logic rst_req,
  input  wire logic supply_ok,
  output logic      async_reset_in_n,
  output logic      core_power_good,
  output logic      host_clock_pos,
  output logic      host_clock_neg,
  output logic      serial_ref_clock_pos,
  output logic      serial_ref_clock_neg
);
  // hub reset follows the request, active low
  assign async_reset_in_n = ~rst_req;
  // power good only once the supply is up at both ends of the hold time
  always begin
    core_power_good = 1'b0;
    wait (supply_ok);
    #(PWR_STABLE_US * 1000 + 5);
    if (supply_ok) core_power_good = 1'b1;
    wait (!supply_ok);
  end
  // free running synthesizer pairs, serial reference at its fixed rate
  initial begin
    host_clock_pos = 1'b0;
    serial_ref_clock_pos = 1'b0;
  end
  always #(HOST_HALF_NS) host_clock_pos = ~host_clock_pos;
  always #(500.0 / SERIAL_REF_MHZ) serial_ref_clock_pos = ~serial_ref_clock_pos;
  assign host_clock_neg = ~host_clock_pos;
  assign serial_ref_clock_neg = ~serial_ref_clock_pos;
endmodule

/* tb.sv */
// self-checking testbench of the hub reset, clock and strap control block
`timescale 1ns/1ps
module tb;
  import hrcsc_pkg::*;
  logic ref_clk = 1'b0, srst = 1'b1, rst_req = 1'b0, supply_ok = 1'b1, therm_n = 1'b1;
  logic conc = 1'b0, slr = 1'b1, chain_in = 1'b0, hiz_in = 1'b0;
  logic arst_n, pg, hcp, hcn, scp, scn, ch_out, ch_oe_n, hz_out, hz_oe_n;
  logic host_clk, mem_clk, pcie_clk, pcie_oe_n, ready;
  hrcsc_strap_t strap;
  hrcsc_therm_t therm;
  logic [LANES-1:0][LANE_W-1:0] lane_map;
  logic [7:0] rnd = 8'h08;
  logic [1:0] exp_strap;
  int err_total = 0, total_checks = 0, n;

  always #20 ref_clk = ~ref_clk;

  hrcsc_platform hrcsc_platform_inst (.rst_req(rst_req), .supply_ok(supply_ok),
    .async_reset_in_n(arst_n), .core_power_good(pg), .host_clock_pos(hcp),
    .host_clock_neg(hcn), .serial_ref_clock_pos(scp), .serial_ref_clock_neg(scn));
  hrcsc_ctrl hrcsc_ctrl_inst (.ref_clk(ref_clk), .srst(srst), .async_reset_in_n(arst_n),
    .core_power_good(pg), .thermal_alert_in_n(therm_n), .concurrent_video_select(conc),
    .lane_reversal_select(slr), .host_clock_pos(hcp), .host_clock_neg(hcn),
    .serial_ref_clock_pos(scp), .serial_ref_clock_neg(scn), .chain_test_pin_in(chain_in),
    .chain_test_pin_out(ch_out), .chain_test_pin_oe_n(ch_oe_n), .hiz_test_pin_in(hiz_in),
    .hiz_test_pin_out(hz_out), .hiz_test_pin_oe_n(hz_oe_n), .host_domain_clk(host_clk),
    .mem_domain_clk(mem_clk), .pcie_ref_clk(pcie_clk), .pcie_out_oe_n(pcie_oe_n),
    .core_ready(ready), .strap(strap), .lane_map(lane_map), .therm(therm));

  // ----------------------------------------------------------------
  // helpers and reference model
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [63:0] exp_map(input logic rev);
    logic [63:0] m;
    m = 64'h0;
    for (int i = 0; i < LANES; i++) m[i*LANE_W +: LANE_W] = rev ? 4'(LANES - 1 - i) : 4'(i);
    return m;
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  // bounded wait for power good (sel 0) or ready (sel 1), a used up bound ends the run
  task automatic wait_for(input int sel, input int lim, output int k);
    k = 0;
    while ((sel == 0 ? pg : ready) !== 1'b1 && k < lim) begin
      cyc(1);
      k++;
    end
    if ((sel == 0 ? pg : ready) !== 1'b1) begin
      err_total++;
      complete_run();
    end
  endtask

  initial begin
    // straps follow the pins while the sync reset is held
    for (int i = 0; i < 10; i++) begin
      rnd = lfsr(rnd);
      conc = rnd[0];
      slr = rnd[1];
      cyc(1);
      chk(64'(strap), {conc, slr == SLR_REVERSED});
      chk({ready, pcie_oe_n, hz_oe_n}, 3'h3);
    end
    exp_strap = {conc, slr == SLR_REVERSED};
    srst = 1'b0;
    conc = ~conc;
    slr = ~slr;
    // ready comes three edges after power good, one edge already passed
    wait_for(0, 400, n);
    wait_for(1, 8, n);
    chk(n, 2);
    chk({pcie_oe_n, strap}, {1'b0, exp_strap});
    chk(lane_map, exp_map(exp_strap[0]));
    // derived clocks track the input pairs
    repeat (6) begin
      @(hcp or scp);
      #0.5;  // off the pair edges, receivers settled
      chk({host_clk, mem_clk, pcie_clk}, {hcp & ~hcn, hcp & ~hcn, scp & ~scn});
    end
    cyc(1);
    // alert onset gives a one-cycle event three edges later
    therm_n = THERM_ACTIVE;
    cyc(2);
    chk(64'(therm), 2'h0);
    cyc(1);
    chk(64'(therm), 2'h3);
    cyc(1);
    chk(64'(therm), 2'h2);
    therm_n = ~THERM_ACTIVE;
    cyc(3);
    chk(64'(therm), 2'h0);
    // async reset acts with no clock edge
    rst_req = 1'b1;
    #2;
    chk({ready, pcie_oe_n, hz_oe_n, strap, therm}, 7'h30);
    cyc(1);
    rnd = lfsr(rnd);
    conc = rnd[0];
    slr = rnd[1];
    rst_req = 1'b0;
    cyc(1);
    chk({ready, strap}, {1'b0, conc, slr == SLR_REVERSED});
    wait_for(1, 8, n);
    chk(n, 2);
    chk(lane_map, exp_map(slr == SLR_REVERSED));
    // chain test: tester request, pin then carries the parity
    hiz_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      chain_in = rnd[2];
      cyc(1);
      chk({ready, hz_oe_n, ch_oe_n, hz_out}, {3'h1, conc ^ slr ^ therm_n ^ pg ^ chain_in});
    end
    srst = 1'b1;
    cyc(1);
    chk({ready, pcie_oe_n, hz_oe_n}, 3'h3);
    complete_run();
  end
endmodule
